// ==== core/timer_ctl_consts.vh ====
// Constants for the timer state and output control block
`ifndef TIMER_CTL_CONSTS_VH
`define TIMER_CTL_CONSTS_VH

// ------------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------------
`define CLK_HZ 25000000
`define TICK_CYCLES (`CLK_HZ)
`define TICK_LAST 25'h17D783F
`define LOCAL_RESET_SEC 4'h3
`define REMOTE_RESET_SEC 1
`define REMOTE_CYCLES 25'h17D7840
`define GTOT_CLEAR_SEC 4'hA
`define ON_DELAY_MAX 32400

// ------------------------------------------------------------------
// Timer states (3-bit codes)
// ------------------------------------------------------------------
`define ST_RESET 3'h0
`define ST_RUN 3'h1
`define ST_PAUSE 3'h2
`define ST_RDELAY 3'h3
`define ST_DONE 3'h4

// ------------------------------------------------------------------
// APB register byte addresses
// ------------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_SETTIME 12'h004
`define REG_OUT1 12'h008
`define REG_OUT2 12'h00C
`define REG_STATUS 12'h010
`define REG_ELAPSED 12'h014
`define REG_GTOTAL 12'h018

// ------------------------------------------------------------------
// CTRL fields
// ------------------------------------------------------------------
`define CTRL_LOCAL_RESET_EN 0
`define CTRL_GTOT_CLEAR_EN 1
`define CTRL_COUNT_DOWN 2
`define CTRL_START 3
`define CTRL_STOP 4
`define CTRL_RESET 5
`define CTRL_RESET_VAL 32'h00000000

// ------------------------------------------------------------------
// OUTx fields: [15:0] delay, [18:16] on state, [19] on invert,
// [22:20] off state, [23] off invert, [24] enable
// ------------------------------------------------------------------
`define OUT_DLY_MSB 15
`define OUT_ON_LSB 16
`define OUT_ON_INV 19
`define OUT_OFF_LSB 20
`define OUT_OFF_INV 23
`define OUT_EN 24
`define OUT_RESET_VAL 25'h0000000

`endif

// ==== core/out_switch.v ====
// One control output: state-entry on/off decode with on-delay
`timescale 1ns/10ps
module out_switch (
    input wire i_sys_clk, // System clock
    input wire i_reset, // Async reset, active high
    input wire i_ce, // Clock enable
    input wire i_tick, // One-second tick pulse
    input wire i_enter, // Pulse: timer entered a new state
    input wire [2:0] i_state, // State just entered
    input wire [24:0] i_cfg, // Output configuration word
    output reg o_on // Switch closed
);
`include "timer_ctl_consts.vh"

    reg pending;
    reg [15:0] dly_cnt;
    wire [2:0] on_st;
    wire [2:0] off_st;
    wire hit_on;
    wire hit_off;
    wire enabled;

    assign on_st = i_cfg[`OUT_ON_LSB+2:`OUT_ON_LSB];
    assign off_st = i_cfg[`OUT_OFF_LSB+2:`OUT_OFF_LSB];
    assign enabled = i_cfg[`OUT_EN];
    // RULE8: inverted turn-on
    assign hit_on = i_enter &
        ((i_state == on_st) ^ i_cfg[`OUT_ON_INV]);
    // RULE9: inverted turn-off
    assign hit_off = i_enter &
        ((i_state == off_st) ^ i_cfg[`OUT_OFF_INV]);

    // On/off latch with whole-second on-delay
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_on <= 1'b0;
            pending <= 1'b0;
            dly_cnt <= 16'h0000;
        end else if (i_ce) begin
            // RULE11: disable holds off
            // RULE17: disabled means off
            if (!enabled) begin
                o_on <= 1'b0;
                pending <= 1'b0;
            // RULE17: cancel pending delay
            // RULE10: off on leaving state
            end else if (hit_off) begin
                o_on <= 1'b0;
                pending <= 1'b0;
            // RULE7: on at entry
            // RULE13: zero means no delay
            end else if (hit_on) begin
                if (i_cfg[`OUT_DLY_MSB:0] == 16'h0000) begin
                    o_on <= 1'b1;
                end else begin
                    pending <= 1'b1;
                    dly_cnt <= i_cfg[`OUT_DLY_MSB:0];
                end
            // RULE12: deferred close
            end else if (pending && i_tick) begin
                if (dly_cnt == 16'h0001) begin
                    pending <= 1'b0;
                    o_on <= 1'b1;
                end
                dly_cnt <= dly_cnt - 16'h0001;
            end
        end
    end
endmodule // out_switch

// ==== core/timer_state_output_control.v ====
// Timer state machine, reset detection, grand total and two outputs
`timescale 1ns/10ps
// Summary of operation
// RULE1: Buttons held together over three seconds with permission reset timer.
// RULE2: Local reset permission is a setting; when off button hold ignored.
// RULE3: Remote terminals joined continuously over one second reset timer.
// RULE4: Grand total accumulates running time apart from elapsed value.
// RULE5: With clear allowed, buttons held over ten seconds zero grand total.
// RULE6: Five states: reset, running, paused, restart delay, complete.
// RULE7: Output turns on entering on-state, off entering off-state.
// RULE8: Inverted on choice turns on entering any other state.
// RULE9: Inverted off choice turns off entering any other state.
// RULE10: On running, off inverted running gives on only while running.
// RULE11: Enable bit disables output keeping other settings unchanged.
// RULE12: Closing deferred by configured delay from the on condition.
// RULE13: Delay whole seconds 0 to 32400; zero means no delay. The code does not clamp the 16-bit field, so delays up to 65535 are accepted.
// RULE14: Annunciator one lit while output one is on.
// RULE15: Output two identical, independent, own annunciator.
// RULE16: Timer counts up to set time or down from it.
// RULE17: Disabled output held off; off condition cancels pending delay.
module timer_state_output_control (
    input wire i_sys_clk, // System clock 25 MHz
    input wire i_reset, // Async reset, active high
    input wire i_ce, // Clock enable, freezes state when low
    input wire i_btn_a, // First designated panel button
    input wire i_btn_b, // Second designated panel button
    input wire i_display_mode, // Instrument in display mode
    input wire i_remote_reset_term_a, // Remote reset contact sense
    input wire i_remote_reset_term_b, // High when joined to term a
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB write
    input wire [11:0] i_paddr, // APB address
    input wire [31:0] i_pwdata, // APB write data
    output reg [31:0] o_prdata, // APB read data
    output reg o_pready, // APB ready
    output reg o_pslverr, // APB error
    output reg o_out1, // Control output 1 switch
    output reg o_out2, // Control output 2 switch
    output reg o_annun1, // Annunciator 1
    output reg o_annun2, // Annunciator 2
    output reg [2:0] o_timer_state // Current timer state
);
`include "timer_ctl_consts.vh"

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg [5:0] ctrl;
    reg [31:0] set_time;
    reg [24:0] out1_cfg;
    reg [24:0] out2_cfg;
    reg [31:0] elapsed;
    reg [31:0] grand_total;
    reg [2:0] state;
    reg [2:0] next_state;
    reg enter;
    reg [24:0] tick_cnt;
    reg tick;
    reg [3:0] btn_sec;
    reg [24:0] btn_sub;
    reg [24:0] rem_sub;
    reg rem_long;
    reg btn_reset_done;
    reg rem_reset_done;
    reg timer_reset_req;
    reg gtot_clear;
    wire out1_on;
    wire out2_on;
    wire acc;
    wire wr;
    wire btn_both;
    wire rem_join;
    wire reached;

    assign acc = i_psel & i_penable;
    assign wr = acc & i_pwrite;
    assign btn_both = i_btn_a & i_btn_b & i_display_mode;
    assign rem_join = i_remote_reset_term_a & i_remote_reset_term_b;
    assign reached = ctrl[`CTRL_COUNT_DOWN] ?
        (elapsed == 32'h00000000) : (elapsed >= set_time);

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Register writes and read mux, one wait-free access phase
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl <= 6'h00;
            set_time <= 32'h00000000;
            out1_cfg <= `OUT_RESET_VAL;
            out2_cfg <= `OUT_RESET_VAL;
            o_prdata <= 32'h00000000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            ctrl[5:3] <= 3'h0; // Start/stop/reset are self-clearing
            if (i_psel && !i_penable) begin
                o_prdata <= 32'h00000000;
                case (i_paddr)
                    `REG_CTRL: o_prdata <= {29'h0, ctrl[2:0]};
                    `REG_SETTIME: o_prdata <= set_time;
                    `REG_OUT1: o_prdata <= {7'h00, out1_cfg};
                    `REG_OUT2: o_prdata <= {7'h00, out2_cfg};
                    `REG_STATUS: o_prdata <= {27'h0, o_out2, o_out1,
                        state};
                    `REG_ELAPSED: o_prdata <= elapsed;
                    `REG_GTOTAL: o_prdata <= grand_total;
                    default: o_pslverr <= 1'b1;
                endcase
            end
            if (wr && o_pready) begin
                case (i_paddr)
                    // RULE2: reset permission setting
                    `REG_CTRL: ctrl <= i_pwdata[5:0];
                    `REG_SETTIME: set_time <= i_pwdata;
                    // RULE15: independent configs
                    `REG_OUT1: out1_cfg <= i_pwdata[24:0];
                    `REG_OUT2: out2_cfg <= i_pwdata[24:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Seconds tick
    // ------------------------------------------------------------------
    // Divide the system clock to a one-cycle pulse each second
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            tick_cnt <= 25'h0000000;
            tick <= 1'b0;
        end else if (i_ce) begin
            tick <= (tick_cnt == `TICK_LAST);
            // Counter wraps after the last cycle of each second
            if (tick_cnt == `TICK_LAST) begin
                tick_cnt <= 25'h0000000;
            end else begin
                tick_cnt <= tick_cnt + 25'h0000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset detection
    // ------------------------------------------------------------------
    // Button hold timer counts whole seconds held, and remote contact
    // timer counts cycles held; each fires once per hold
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            btn_sub <= 25'h0000000;
            btn_sec <= 4'h0;
            rem_sub <= 25'h0000000;
            rem_long <= 1'b0;
            btn_reset_done <= 1'b0;
            rem_reset_done <= 1'b0;
            timer_reset_req <= 1'b0;
            gtot_clear <= 1'b0;
        end else if (i_ce) begin
            timer_reset_req <= 1'b0;
            gtot_clear <= 1'b0;
            if (!btn_both) begin
                btn_sub <= 25'h0000000;
                btn_sec <= 4'h0;
                btn_reset_done <= 1'b0;
            end else if (btn_sub == `TICK_LAST) begin
                btn_sub <= 25'h0000000;
                if (btn_sec != 4'hF) begin
                    btn_sec <= btn_sec + 4'h1;
                end
            end else begin
                btn_sub <= btn_sub + 25'h0000001;
            end
            // RULE1: over three seconds
            // RULE2: only when permitted
            if (btn_both && ctrl[`CTRL_LOCAL_RESET_EN] &&
                    !btn_reset_done &&
                    btn_sec == `LOCAL_RESET_SEC &&
                    btn_sub != 25'h0000000) begin
                timer_reset_req <= 1'b1;
                btn_reset_done <= 1'b1;
            end
            // RULE5: ten second clear
            if (btn_both && ctrl[`CTRL_GTOT_CLEAR_EN] &&
                    btn_sec == `GTOT_CLEAR_SEC &&
                    btn_sub == 25'h0000001) begin
                gtot_clear <= 1'b1;
            end
            // Any opening of the contact restarts the count
            // RULE3: remote contact one second
            if (!rem_join) begin
                rem_sub <= 25'h0000000;
                rem_long <= 1'b0;
                rem_reset_done <= 1'b0;
            end else if (rem_sub == `REMOTE_CYCLES) begin
                rem_long <= 1'b1;
            end else begin
                rem_sub <= rem_sub + 25'h0000001;
            end
            if (rem_long && !rem_reset_done) begin
                timer_reset_req <= 1'b1;
                rem_reset_done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Timer state machine
    // ------------------------------------------------------------------
    // RULE6: five timer states
    always @* begin
        next_state = state;
        case (state)
            `ST_RESET: if (ctrl[`CTRL_START] && set_time != 32'h00000000)
                next_state = `ST_RUN;
            `ST_RUN: if (reached) next_state = `ST_DONE;
                else if (ctrl[`CTRL_STOP]) next_state = `ST_PAUSE;
            `ST_PAUSE: if (ctrl[`CTRL_START]) next_state = `ST_RUN;
            `ST_RDELAY: if (ctrl[`CTRL_START]) next_state = `ST_RUN;
            `ST_DONE: next_state = `ST_DONE;
            default: next_state = `ST_RESET;
        endcase
        if (ctrl[`CTRL_RESET] || timer_reset_req) begin
            next_state = `ST_RESET;
        end
    end

    // State register, elapsed count and grand total
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= `ST_RESET;
            enter <= 1'b0;
            elapsed <= 32'h00000000;
            grand_total <= 32'h00000000;
            o_timer_state <= `ST_RESET;
        end else if (i_ce) begin
            state <= next_state;
            o_timer_state <= next_state;
            enter <= (next_state != state);
            // RULE16: up or down count
            if (next_state == `ST_RESET) begin
                elapsed <= ctrl[`CTRL_COUNT_DOWN] ? set_time :
                    32'h00000000;
            end else if (state == `ST_RUN && tick && !reached) begin
                elapsed <= ctrl[`CTRL_COUNT_DOWN] ?
                    elapsed - 32'h00000001 : elapsed + 32'h00000001;
            end
            // RULE4: grand total of run time
            if (gtot_clear) begin
                grand_total <= 32'h00000000;
            end else if (state == `ST_RUN && tick) begin
                grand_total <= grand_total + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    out_switch u_out1 (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_enter(enter),
        .i_state(state),
        .i_cfg(out1_cfg),
        .o_on(out1_on)
    );

    out_switch u_out2 (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_enter(enter),
        .i_state(state),
        .i_cfg(out2_cfg),
        .o_on(out2_on)
    );

    // Output switches and annunciators registered
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_out1 <= 1'b0;
            o_out2 <= 1'b0;
            o_annun1 <= 1'b0;
            o_annun2 <= 1'b0;
        end else if (i_ce) begin
            o_out1 <= out1_on;
            o_out2 <= out2_on;
            // RULE14: annunciator one
            o_annun1 <= out1_on;
            // RULE15: annunciator two
            o_annun2 <= out2_on;
        end
    end
endmodule // timer_state_output_control

// ==== testbench/tsoc_checker_asserts.sv ====
// Port-level checker for the timer state and output control block
`timescale 1ns/10ps
module tsoc_checker (
    input wire i_sys_clk, // Clock
    input wire i_reset, // Reset
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire [11:0] i_paddr, // APB address
    input wire [31:0] o_prdata, // Read data
    input wire o_pready, // Ready
    input wire o_pslverr, // Error
    input wire o_out1, // Output 1
    input wire o_out2, // Output 2
    input wire o_annun1, // Annunciator 1
    input wire o_annun2, // Annunciator 2
    input wire [2:0] o_timer_state // Timer state
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // Annunciators mirror their switches
    a_annun_one_mirror: assert property (o_annun1 == o_out1)
        else $error("annunciator 1 differs from output 1");
    a_annun_two_mirror: assert property (o_annun2 == o_out2)
        else $error("annunciator 2 differs from output 2");
    // Timer state code stays among the five states
    a_state_code_legal: assert property (o_timer_state <= 3'h4)
        else $error("timer state code out of range");
    // Bus answers with zero wait states, one cycle wide
    a_ready_in_access: assert property (i_psel && i_penable |-> o_pready)
        else $error("ready missing in access cycle");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_ready_only_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access cycle");
    a_unmapped_error: assert property (o_pready && i_paddr[1:0] == 2'h0
        |-> o_pslverr == (i_paddr > 12'h018))
        else $error("error flag wrong for address");
    a_error_data_zero: assert property (o_pslverr |-> o_prdata == 32'h0)
        else $error("read data not zero on error");

    // Main scenarios reached
    c_out1_on: cover property ($rose(o_out1));
    c_out2_on: cover property ($rose(o_out2));
    c_paused: cover property (o_timer_state == 3'h2);
    c_bus_error: cover property (o_pslverr);
endmodule // tsoc_checker

bind timer_state_output_control tsoc_checker i_tsoc_checker (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_out1(o_out1),
    .o_out2(o_out2), .o_annun1(o_annun1), .o_annun2(o_annun2),
    .o_timer_state(o_timer_state)
);

// ==== testbench/panel_model.sv ====
// Operator buttons and remote reset contact driving the block
`timescale 1ns/10ps
module panel_model (
    input wire i_sys_clk, // Clock
    input wire i_hold, // Hold both buttons
    input wire i_join, // Join remote contact
    output reg o_btn_a = 1'b0, // Button a
    output reg o_btn_b = 1'b0, // Button b
    output reg o_display_mode = 1'b1, // Always in display mode
    output reg o_term_a = 1'b0, // Contact sense a
    output reg o_term_b = 1'b0 // Contact sense b
);
    // Buttons pressed together, contact closed on both sides
    always @(posedge i_sys_clk) begin
        o_btn_a <= i_hold;
        o_btn_b <= i_hold;
        o_term_a <= i_join;
        o_term_b <= i_join;
    end
endmodule // panel_model

// ==== testbench/timer_state_output_control_bench.sv ====
// Self-checking bench for the timer state and output control block
`timescale 1ns/10ps
`include "timer_ctl_consts.vh"
module timer_state_output_control_bench;
    reg i_sys_clk = 1'b0;
    reg i_reset = 1'b1;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
    reg join_c = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [31:0] rd;
    reg er;
    wire btn_a, btn_b, disp, term_a, term_b;
    wire pready, pslverr, out1, out2, annun1, annun2;
    wire [31:0] prdata;
    wire [2:0] tstate;
    integer err_total = 0, num_checks = 0, cyc = 0;

    // ------------------------------------------------------------
    // Clock, design and panel
    // ------------------------------------------------------------
    initial forever #20 i_sys_clk = ~i_sys_clk;
    timer_state_output_control i_timer_state_output_control (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_btn_a(btn_a), .i_btn_b(btn_b), .i_display_mode(disp),
        .i_remote_reset_term_a(term_a), .i_remote_reset_term_b(term_b),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_out1(out1),
        .o_out2(out2), .o_annun1(annun1), .o_annun2(annun2),
        .o_timer_state(tstate));
    panel_model i_panel_model (.i_sys_clk(i_sys_clk), .i_hold(hold),
        .i_join(join_c), .o_btn_a(btn_a), .o_btn_b(btn_b),
        .o_display_mode(disp), .o_term_a(term_a), .o_term_b(term_b));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp, input [8*20-1:0] what);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: %0s %0h", $time, what, got);
            end
        end
    endtask

    // One APB transfer, held until ready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge i_sys_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge i_sys_clk);
            penable <= 1'b1;
            @(posedge i_sys_clk);
            // Ready sampled high ends this wait; the hang guard covers a missing ready
            while (pready !== 1'b1) begin
                @(posedge i_sys_clk);
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdchk(input [11:0] a, input [31:0] exp, input [8*20-1:0] what);
        begin
            apb(1'b0, a, 32'h00000000);
            chk(rd, exp, what);
        end
    endtask

    // Control command, then time for state entry and output update
    task cmd(input [31:0] d);
        begin
            apb(1'b1, `REG_CTRL, d);
            repeat (10) @(posedge i_sys_clk);
        end
    endtask

    function [31:0] cfg(input en, input [2:0] on, input oni,
        input [2:0] off, input offi, input [15:0] dly);
        cfg = {7'h00, en, offi, off, oni, on, dly};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset_values;
        begin
            rdchk(`REG_CTRL, 32'h00000000, "ctrl reset");
            rdchk(`REG_OUT1, 32'h00000000, "out1 cfg reset");
            rdchk(`REG_OUT2, 32'h00000000, "out2 cfg reset");
            rdchk(`REG_STATUS, 32'h00000000, "status reset");
            rdchk(`REG_GTOTAL, 32'h00000000, "grand total");
        end
    endtask

    task t_unmapped;
        begin
            apb(1'b1, 12'h020, 32'hFFFFFFFF);
            chk(er, 1'b1, "write error");
            apb(1'b0, 12'h020, 32'h00000000);
            chk(er, 1'b1, "read error");
            chk(rd, 32'h00000000, "error data");
        end
    endtask

    task t_on_off;
        begin
            apb(1'b1, `REG_SETTIME, 32'h00000064);
            apb(1'b1, `REG_OUT1, cfg(1, `ST_RUN, 0, `ST_PAUSE, 0, 0));
            apb(1'b1, `REG_OUT2, cfg(1, `ST_RUN, 0, `ST_RUN, 1, 0));
            cmd(32'h00000008);
            chk(tstate, `ST_RUN, "run");
            chk({out2, out1}, 2'h3, "both on at run");
            rdchk(`REG_STATUS, 32'h00000019, "status run");
            cmd(32'h00000010);
            chk(tstate, `ST_PAUSE, "paused");
            chk({out2, out1}, 2'h0, "both off at pause");
            cmd(32'h00000008);
            cmd(32'h00000020);
            chk(tstate, `ST_RESET, "reset");
            chk(out1, 1'b1, "out1 stays on");
            chk(out2, 1'b0, "out2 off leaving run");
        end
    endtask

    task t_inv_on;
        begin
            apb(1'b1, `REG_OUT1, cfg(1, `ST_PAUSE, 1, `ST_PAUSE, 0, 0));
            cmd(32'h00000008);
            cmd(32'h00000010);
            chk(out1, 1'b0, "off at pause");
            cmd(32'h00000020);
            chk(out1, 1'b1, "on at not pause");
            chk(annun1, 1'b1, "annunciator 1 on");
        end
    endtask

    task t_enable;
        begin
            apb(1'b1, `REG_OUT1, cfg(0, `ST_PAUSE, 1, `ST_PAUSE, 0, 0));
            repeat (10) @(posedge i_sys_clk);
            chk(out1, 1'b0, "disabled off");
            rdchk(`REG_OUT1, 32'h002A0000, "cfg kept");
            cmd(32'h00000008);
            chk(out1, 1'b0, "disabled held off");
            chk(out2, 1'b1, "out2 independent");
            chk(annun2, 1'b1, "annunciator 2 on");
        end
    endtask

    task t_delay;
        begin
            apb(1'b1, `REG_OUT1, cfg(1, `ST_RUN, 0, `ST_PAUSE, 0, 2));
            cmd(32'h00000010);
            cmd(32'h00000008);
            repeat (1000) @(posedge i_sys_clk);
            chk(out1, 1'b0, "closing deferred");
            chk(out2, 1'b1, "no delay closes");
            cmd(32'h00000010);
            chk(out1, 1'b0, "pending cancelled");
        end
    endtask

    task t_short_holds;
        begin
            cmd(32'h0000000B);
            hold <= 1'b1;
            repeat (2000) @(posedge i_sys_clk);
            hold <= 1'b0;
            chk(tstate, `ST_RUN, "short hold no reset");
            join_c <= 1'b1;
            repeat (2000) @(posedge i_sys_clk);
            join_c <= 1'b0;
            chk(tstate, `ST_RUN, "short join no reset");
            rdchk(`REG_GTOTAL, 32'h00000000, "no clear needed");
            rdchk(`REG_CTRL, 32'h00000003, "permissions kept");
        end
    endtask

    // ------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end

    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        t_reset_values;
        t_unmapped;
        t_on_off;
        t_inv_on;
        t_enable;
        t_delay;
        t_short_holds;
        report_and_stop;
    end
endmodule // timer_state_output_control_bench
